// ### fbdc_defines.vh
// Purpose: Constants for the first synthesizer loop feedback divider configuration block
// Assumes: Byte-wide register port with 16-bit addresses, one clock
// Notes: Included by fbdc_top.v; fbdc_shadow.v does not include it
//
// Notes on behaviour
// R01 - Modulus bits spread over three byte registers
// R02 - Host keeps modulus above numerator, max 20 bits
// R03 - Auxiliary divider is 12 bits over two registers
// R04 - Aux value 0 or 1 bypasses, forbids loop two
// R05 - Aux 4..4095 divides; 2..3 undefined, avoid
// R06 - Loop four always bypasses auxiliary divider
// R07 - Post-divider is low nibble; upper nibble unused
// R08 - Post codes 0..2 disable, 3..11 divide
// R09 - Post codes 12..14 suppress VCO calibration
// R10 - Post code 15 holds divider in reset
// R11 - Host stages code 15 then new value
// R12 - Bit 0 write at 0x0005 commits staged settings
// R13 - Zero numerator means integer mode, modulator off
`ifndef FBDC_DEFINES_VH
`define FBDC_DEFINES_VH

// Register addresses
`define FBDC_ADDR_UPDATE 16'h0005
`define FBDC_ADDR_MOD_LO 16'h010A
`define FBDC_ADDR_MOD_MID 16'h010B
`define FBDC_ADDR_MOD_HI 16'h010C
`define FBDC_ADDR_AUX_LO 16'h010D
`define FBDC_ADDR_AUX_HI 16'h010E
`define FBDC_ADDR_POST 16'h010F

// Field positions
`define FBDC_UPDATE_BIT 0

// Reset values
`define FBDC_RST_MOD 20'h00000
`define FBDC_RST_AUX 12'h000
`define FBDC_RST_POST 4'h0

// Code thresholds
`define FBDC_AUX_BYPASS_MAX 12'h001
`define FBDC_AUX_DIV_MIN 12'h004
`define FBDC_POST_DIS_MAX 4'h2
`define FBDC_POST_DIV_MAX 4'hB
`define FBDC_POST_RESET 4'hF

// Loop arrangement codes
`define FBDC_LOOP_TWO 2'h1
`define FBDC_LOOP_FOUR 2'h3

`endif

// ### fbdc_properties.sv
// Purpose: Port-level checks for the feedback divider configuration block
// Assumes: One clock, synchronous active-low reset, outputs land 2 edges after an update
// Notes: Bound onto fbdc_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module fbdc_properties (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Register port
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  // Neighbour inputs
  input wire [1:0] loop_sel_i,
  input wire [19:0] fractional_numerator_field_i,
  // Committed values and decodes
  input wire [19:0] fractional_modulus_field_o,
  input wire integer_mode_o,
  input wire [11:0] auxiliary_feedback_divider_o,
  input wire aux_bypass_o,
  input wire aux_divide_o,
  input wire loop_two_forbidden_o,
  input wire [3:0] vco_post_divider_o,
  input wire post_disable_o,
  input wire post_divide_o,
  input wire post_reset_o,
  input wire cal_suppress_o,
  input wire vco_cal_req_o
);
  ////////////////////////////////////////
  // Update write seen at the port
  wire upd = reg_wr_i && reg_addr_i == 16'h0005 && reg_wdata_i[0];
  // Short name for the committed post code
  wire [3:0] pc = vco_post_divider_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  chk_post_off: assert property (post_disable_o == (pc <= 4'h2)) else $error("post disable decode wrong");
  chk_post_div: assert property (post_divide_o == (pc >= 4'h3 && pc <= 4'hB)) else $error("post divide wrong");
  chk_cal_hold: assert property (cal_suppress_o == (pc >= 4'hC && pc <= 4'hE)) else $error("cal hold wrong");
  chk_post_rst: assert property (post_reset_o == (pc == 4'hF)) else $error("post reset decode wrong");
  chk_loop_two: assert property (loop_two_forbidden_o == (auxiliary_feedback_divider_o <= 12'h001))
    else $error("loop two forbid wrong");
  chk_loop_four: assert property ((loop_sel_i == 2'h3) [*2] |=> aux_bypass_o && !aux_divide_o)
    else $error("loop four not bypassed");
  chk_aux_div: assert property (aux_divide_o |-> auxiliary_feedback_divider_o >= 12'h004 && !aux_bypass_o)
    else $error("aux divide wrong");
  chk_int_mode: assert property (1'b1 |=> integer_mode_o == ($past(fractional_numerator_field_i) == 20'h0))
    else $error("integer mode wrong");
  chk_commit_post: assert property ((reg_wr_i && reg_addr_i == 16'h010F) ##1 !reg_wr_i ##1 upd |->
    ##2 pc == $past(reg_wdata_i[3:0], 4)) else $error("post code not committed");
  chk_hold_cfg: assert property (!upd |-> ##2 $stable({fractional_modulus_field_o,
    auxiliary_feedback_divider_o, pc})) else $error("config moved without update");
  chk_cal_pulse: assert property (vco_cal_req_o |-> pc != $past(pc) && pc != 4'hF && $past(pc) != 4'hF
    && !cal_suppress_o ##1 !vco_cal_req_o) else $error("bad calibration request");
  // Main scenarios reached
  cov_update: cover property (upd);
  cov_cal_req: cover property (vco_cal_req_o);
  cov_post_rst: cover property (post_reset_o);
endmodule // fbdc_properties
bind fbdc_top fbdc_properties u_props (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .loop_sel_i, .fractional_numerator_field_i, .fractional_modulus_field_o, .integer_mode_o,
  .auxiliary_feedback_divider_o, .aux_bypass_o, .aux_divide_o, .loop_two_forbidden_o,
  .vco_post_divider_o, .post_disable_o, .post_divide_o, .post_reset_o, .cal_suppress_o, .vco_cal_req_o);
`default_nettype wire

// ### fbdc_shadow.v
// Purpose: Staged register with a committed copy
// Assumes: Write and commit are one-cycle pulses
// Notes: Commit copies the staged value, or the byte written in the same cycle
`timescale 1ns/10ps
`default_nettype none

module fbdc_shadow #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Write side
  input wire wr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire commit_i,
  // Values
  output wire [WIDTH-1:0] staged_o,
  output wire [WIDTH-1:0] active_o
);

  reg [WIDTH-1:0] staged_ff; // Value software last wrote
  reg [WIDTH-1:0] active_ff; // Value the divider logic uses
  wire [WIDTH-1:0] nxt_staged;

  // Pending write folds in so a same-cycle commit sees it
  assign nxt_staged = wr_i ? wdata_i : staged_ff;

  ////////////////////////////////////////////////////////////////
  // Staged and committed storage
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      staged_ff <= RESET_VALUE;
      active_ff <= RESET_VALUE;
    end else begin
      staged_ff <= nxt_staged;
      if (commit_i) begin
        active_ff <= nxt_staged; // [R12]
      end
    end
  end

  assign staged_o = staged_ff;
  assign active_o = active_ff;

endmodule // fbdc_shadow

`default_nettype wire

// ### fbdc_top.v
// Purpose: Feedback divider configuration for the first synthesizer loop
// Assumes: Register port is byte wide, writes and reads take effect on the clock
// Notes: Settings take effect only on an input/output update
`timescale 1ns/10ps
`default_nettype none
`include "fbdc_defines.vh"

module fbdc_top (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Register port
  input wire [15:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Loop arrangement and numerator from neighbouring logic
  input wire [1:0] loop_sel_i,
  input wire [19:0] fractional_numerator_field_i,
  // Main feedback divider controls
  output reg [19:0] fractional_modulus_field_o,
  output reg integer_mode_o,
  // Auxiliary feedback divider controls
  output reg [11:0] auxiliary_feedback_divider_o,
  output reg aux_bypass_o,
  output reg aux_divide_o,
  output reg loop_two_forbidden_o,
  // VCO post-divider controls
  output reg [3:0] vco_post_divider_o,
  output reg post_disable_o,
  output reg post_divide_o,
  output reg post_reset_o,
  output reg cal_suppress_o,
  output reg vco_cal_req_o
);

  // Writes land in a staged copy of each field; a write of one to the
  // update bit copies every staged field into its active copy at once,
  // so a multi-byte divider never shows a half-written value. Reads
  // return the staged copy. Decode flags follow the active copy with
  // one more flop, so they move two edges after the update write.

  ////////////////////////////////////////////////////////////////
  // Address decode

  wire wr_mod_lo;
  wire wr_mod_mid;
  wire wr_mod_hi;
  wire wr_aux_lo;
  wire wr_aux_hi;
  wire wr_post;
  wire io_update; // Commit pulse

  assign wr_mod_lo = reg_wr_i && (reg_addr_i == `FBDC_ADDR_MOD_LO);
  assign wr_mod_mid = reg_wr_i && (reg_addr_i == `FBDC_ADDR_MOD_MID);
  assign wr_mod_hi = reg_wr_i && (reg_addr_i == `FBDC_ADDR_MOD_HI);
  assign wr_aux_lo = reg_wr_i && (reg_addr_i == `FBDC_ADDR_AUX_LO);
  assign wr_aux_hi = reg_wr_i && (reg_addr_i == `FBDC_ADDR_AUX_HI);
  assign wr_post = reg_wr_i && (reg_addr_i == `FBDC_ADDR_POST);
  // Write of one to bit 0 commits all staged fields
  assign io_update = reg_wr_i && (reg_addr_i == `FBDC_ADDR_UPDATE)
                     && reg_wdata_i[`FBDC_UPDATE_BIT]; // [R12]

  ////////////////////////////////////////////////////////////////
  // Staged storage

  wire [7:0] mod_lo_s;
  wire [7:0] mod_mid_s;
  wire [3:0] mod_hi_s;
  wire [7:0] aux_lo_s;
  wire [3:0] aux_hi_s;
  wire [3:0] post_s;
  wire [7:0] mod_lo_a;
  wire [7:0] mod_mid_a;
  wire [3:0] mod_hi_a;
  wire [7:0] aux_lo_a;
  wire [3:0] aux_hi_a;
  wire [3:0] post_a;

  // Reset images of the multi-byte fields, sliced per register
  localparam [19:0] RST_MOD = `FBDC_RST_MOD;
  localparam [11:0] RST_AUX = `FBDC_RST_AUX;

  // Modulus bits 7:0
  fbdc_shadow #(
    .WIDTH(8),
    .RESET_VALUE(RST_MOD[7:0])
  ) u_mod_lo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_mod_lo),
    .wdata_i(reg_wdata_i),
    .commit_i(io_update),
    .staged_o(mod_lo_s),
    .active_o(mod_lo_a)
  );
  // Modulus bits 15:8
  fbdc_shadow #(
    .WIDTH(8),
    .RESET_VALUE(RST_MOD[15:8])
  ) u_mod_mid (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_mod_mid),
    .wdata_i(reg_wdata_i),
    .commit_i(io_update),
    .staged_o(mod_mid_s),
    .active_o(mod_mid_a)
  );
  // Modulus bits 19:16, low nibble only
  fbdc_shadow #(
    .WIDTH(4),
    .RESET_VALUE(RST_MOD[19:16])
  ) u_mod_hi (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_mod_hi),
    .wdata_i(reg_wdata_i[3:0]), // [R01]
    .commit_i(io_update),
    .staged_o(mod_hi_s),
    .active_o(mod_hi_a)
  );
  // Auxiliary divider bits 7:0
  fbdc_shadow #(
    .WIDTH(8),
    .RESET_VALUE(RST_AUX[7:0])
  ) u_aux_lo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_aux_lo),
    .wdata_i(reg_wdata_i),
    .commit_i(io_update),
    .staged_o(aux_lo_s),
    .active_o(aux_lo_a)
  );
  // Auxiliary divider bits 11:8
  fbdc_shadow #(
    .WIDTH(4),
    .RESET_VALUE(RST_AUX[11:8])
  ) u_aux_hi (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_aux_hi),
    .wdata_i(reg_wdata_i[3:0]), // [R03]
    .commit_i(io_update),
    .staged_o(aux_hi_s),
    .active_o(aux_hi_a)
  );
  // Post-divider code, upper nibble dropped
  fbdc_shadow #(
    .WIDTH(4),
    .RESET_VALUE(`FBDC_RST_POST)
  ) u_post (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_post),
    .wdata_i(reg_wdata_i[3:0]), // [R07]
    .commit_i(io_update),
    .staged_o(post_s),
    .active_o(post_a)
  );

  ////////////////////////////////////////////////////////////////
  // Decode of committed values

  wire [19:0] mod_a;
  wire [11:0] aux_a;
  reg nxt_aux_bypass;
  reg nxt_aux_divide;
  reg nxt_post_disable;
  reg nxt_post_divide;
  reg nxt_cal_suppress;

  assign mod_a = {mod_hi_a, mod_mid_a, mod_lo_a}; // [R01]
  assign aux_a = {aux_hi_a, aux_lo_a}; // [R03]

  // Auxiliary divider mode from value and loop arrangement
  // Values 2 and 3 leave both flags low outside loop four; software is to avoid them
  always @* begin
    nxt_aux_bypass = 1'b0;
    nxt_aux_divide = 1'b0;
    if (loop_sel_i == `FBDC_LOOP_FOUR) begin
      nxt_aux_bypass = 1'b1; // [R06]
    end else if (aux_a <= `FBDC_AUX_BYPASS_MAX) begin
      nxt_aux_bypass = 1'b1; // [R04]
    end else if (aux_a >= `FBDC_AUX_DIV_MIN) begin
      nxt_aux_divide = 1'b1; // [R05]
    end
  end

  // Post-divider mode from code
  // Code 15 raises no flag here; the reset output decodes it
  always @* begin
    nxt_post_disable = 1'b0;
    nxt_post_divide = 1'b0;
    nxt_cal_suppress = 1'b0;
    if (post_a <= `FBDC_POST_DIS_MAX) begin
      nxt_post_disable = 1'b1; // [R08]
    end else if (post_a <= `FBDC_POST_DIV_MAX) begin
      nxt_post_divide = 1'b1; // [R08]
    end else if (post_a != `FBDC_POST_RESET) begin
      nxt_cal_suppress = 1'b1; // [R09]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Calibration request tracking

  reg [3:0] prev_post_ff; // Committed code seen last cycle
  wire post_changed; // Committed code moved on the last update

  assign post_changed = (post_a != prev_post_ff);

  // Remember prior code so a change is seen for exactly one cycle.
  // Entering or leaving code 15 never asks for calibration: software
  // parks the divider in reset, commits, then commits the new value,
  // and the loop must keep its present VCO band across that swap.
  // Entering codes 12 to 14 likewise changes the divider without a calibration.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      prev_post_ff <= `FBDC_RST_POST;
    end else begin
      prev_post_ff <= post_a;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registered outputs

  // Calibration requested on a change, unless suppressed or staged via reset
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      fractional_modulus_field_o <= `FBDC_RST_MOD;
      integer_mode_o <= 1'b1;
      auxiliary_feedback_divider_o <= `FBDC_RST_AUX;
      aux_bypass_o <= 1'b1;
      aux_divide_o <= 1'b0;
      loop_two_forbidden_o <= 1'b1;
      vco_post_divider_o <= `FBDC_RST_POST;
      post_disable_o <= 1'b1;
      post_divide_o <= 1'b0;
      post_reset_o <= 1'b0;
      cal_suppress_o <= 1'b0;
      vco_cal_req_o <= 1'b0;
    end else begin
      fractional_modulus_field_o <= mod_a;
      integer_mode_o <= (fractional_numerator_field_i == 20'h00000); // [R13]
      auxiliary_feedback_divider_o <= aux_a;
      aux_bypass_o <= nxt_aux_bypass;
      aux_divide_o <= nxt_aux_divide;
      loop_two_forbidden_o <= (aux_a <= `FBDC_AUX_BYPASS_MAX); // [R04]
      vco_post_divider_o <= post_a;
      post_disable_o <= nxt_post_disable;
      post_divide_o <= nxt_post_divide;
      post_reset_o <= (post_a == `FBDC_POST_RESET); // [R10]
      cal_suppress_o <= nxt_cal_suppress;
      vco_cal_req_o <= post_changed && !nxt_cal_suppress
                       && (post_a != `FBDC_POST_RESET)
                       && (prev_post_ff != `FBDC_POST_RESET); // [R09]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read back of staged values, unused bits as zero

  reg [7:0] nxt_rdata;

  always @* begin
    if (reg_addr_i == `FBDC_ADDR_MOD_LO) begin
      nxt_rdata = mod_lo_s;
    end else if (reg_addr_i == `FBDC_ADDR_MOD_MID) begin
      nxt_rdata = mod_mid_s;
    end else if (reg_addr_i == `FBDC_ADDR_MOD_HI) begin
      nxt_rdata = {4'h0, mod_hi_s};
    end else if (reg_addr_i == `FBDC_ADDR_AUX_LO) begin
      nxt_rdata = aux_lo_s;
    end else if (reg_addr_i == `FBDC_ADDR_AUX_HI) begin
      nxt_rdata = {4'h0, aux_hi_s};
    end else if (reg_addr_i == `FBDC_ADDR_POST) begin
      nxt_rdata = {4'h0, post_s};
    end else begin
      nxt_rdata = 8'h00; // Unmapped and update register read zero
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

endmodule // fbdc_top

`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the feedback divider configuration block
// Assumes: 25 MHz clock, synchronous active-low reset held 20 cycles
// Notes: Drivers queue expectations, a monitor compares them in order
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
  // Design inputs, all valued at time zero
  logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [15:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0;
  logic [1:0] loop_sel_i = 0;
  logic [19:0] fractional_numerator_field_i = 0;
  // Design outputs
  wire [7:0] reg_rdata_o;
  wire [19:0] mod_o;
  wire [11:0] aux_o;
  wire [3:0] post_o;
  wire [8:0] flg_o;
  // Bench state
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] seed = 60;
  logic [19:0] m;
  logic [11:0] a;
  logic [3:0] p, old_pc = 0;
  logic [11:0] aux_tab[6] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'hFFF};
  logic [3:0] stg_tab[4] = '{4'h5, 4'hF, 4'h9, 4'h4};
  logic rd1 = 0, u1 = 0, u2 = 0;
  int error_cnt = 0, checked = 0, cyc = 0;
  fbdc_top dut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .loop_sel_i, .fractional_numerator_field_i, .fractional_modulus_field_o(mod_o),
    .auxiliary_feedback_divider_o(aux_o), .vco_post_divider_o(post_o), .integer_mode_o(flg_o[8]),
    .aux_bypass_o(flg_o[7]), .aux_divide_o(flg_o[6]), .loop_two_forbidden_o(flg_o[5]),
    .post_disable_o(flg_o[4]), .post_divide_o(flg_o[3]), .post_reset_o(flg_o[2]),
    .cal_suppress_o(flg_o[1]), .vco_cal_req_o(flg_o[0]));
  ////////////////////////////////////////
  // Clock and hang guard
  initial forever #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected committed values and decodes
  function automatic logic [63:0] dec(input logic [19:0] m, input logic [11:0] a, input logic [3:0] p,
    input logic [3:0] o, input logic [1:0] l, input logic [19:0] n);
    logic s;
    s = p >= 4'hC && p <= 4'hE;
    return {m, a, p, n == 20'h0, l == 2'h3 || a <= 12'h001, l != 2'h3 && a >= 12'h004, a <= 12'h001,
      p <= 4'h2, p >= 4'h3 && p <= 4'hB, p == 4'hF, s, p != o && p != 4'hF && o != 4'hF && !s};
  endfunction
  // One register access, strobe held for one edge
  task automatic acc(input logic w, input logic [15:0] ad, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge clock_i);
    reg_wr_i <= 0;
    reg_rd_i <= 0;
  endtask
  // Read with a queued expectation
  task automatic rd(input logic [15:0] ad, input logic [7:0] x);
    exp_q.push_back({56'h0, x});
    acc(0, ad, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Monitor: read data one edge after a read, decodes two edges after an update
  always @(posedge clock_i) begin
    rd1 <= reg_rd_i;
    u1 <= reg_wr_i && reg_addr_i == 16'h0005 && reg_wdata_i[0];
    u2 <= u1;
    if (rd1 || u2) begin
      e = exp_q.pop_front();
      `CHK(rd1 ? "rdata" : "cfg", e, rd1 ? {56'h0, reg_rdata_o} : {19'h0, mod_o, aux_o, post_o, flg_o})
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1;
    // Reset contents, unmapped 0x0110, update with nothing staged
    for (int r = 16'h010A; r <= 16'h0110; r++) rd(r[15:0], 8'h00);
    exp_q.push_back(dec(20'h0, 12'h000, 4'h0, 4'h0, 2'h0, 20'h0));
    acc(1, 16'h0005, 8'h01);
    $display("test reset done");
    // Every post code, aux boundaries, every loop arrangement
    for (int i = 0; i < 16; i++) begin
      @(posedge clock_i); // Previous check still sees the old inputs
      seed = xs(seed);
      m = seed[19:0] | 20'h00001;
      a = i < 6 ? aux_tab[i] : seed[31:20];
      p = i[3:0];
      loop_sel_i <= i[1:0];
      fractional_numerator_field_i <= i[1:0] == 2'h0 ? 20'h0 : m >> 1;
      acc(1, 16'h010A, m[7:0]);
      acc(1, 16'h010B, m[15:8]);
      acc(1, 16'h010C, {seed[27:24], m[19:16]});
      acc(1, 16'h010D, a[7:0]);
      acc(1, 16'h010E, {seed[23:20], a[11:8]});
      acc(1, 16'h010F, {seed[11:8], p});
      acc(1, 16'h0005, 8'hFE);
      rd(16'h010C, {4'h0, m[19:16]});
      rd(16'h010E, {4'h0, a[11:8]});
      rd(16'h010F, {4'h0, p});
      exp_q.push_back(dec(m, a, p, old_pc, i[1:0], i[1:0] == 2'h0 ? 20'h0 : m >> 1));
      acc(1, 16'h0005, {seed[7:1], 1'b1});
      old_pc = p;
    end
    $display("test codes done");
    // Post code parked in reset and committed, then a direct change
    @(posedge clock_i);
    loop_sel_i <= 2'h0;
    fractional_numerator_field_i <= 20'h0;
    foreach (stg_tab[k]) begin
      seed = xs(seed);
      exp_q.push_back(dec(m, a, stg_tab[k], old_pc, 2'h0, 20'h0));
      acc(1, 16'h010F, {seed[7:4], stg_tab[k]});
      acc(1, 16'h0005, {seed[15:9], 1'b1});
      old_pc = stg_tab[k];
    end
    $display("test staging done");
    repeat (4) @(posedge clock_i);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
